//--- rtl/swrc_pkg.sv
// Constants, state codes and status carrier of the standby and reset control
`default_nettype none
package swrc_pkg;
    localparam int unsigned SYS_CLK_PERIOD_NS   = 8;
    // External reset pin must stay low this long to count as a reset
    localparam int unsigned EXT_RESET_MIN_NS    = 2000;
    localparam int unsigned EXT_RESET_CYCLES    =
        (EXT_RESET_MIN_NS + SYS_CLK_PERIOD_NS - 1) / SYS_CLK_PERIOD_NS;
    // Typical hold after STOP release before normal operation resumes
    localparam int unsigned RESTART_HOLD_NS     = 34000;
    localparam int unsigned RESTART_HOLD_CYCLES = RESTART_HOLD_NS / SYS_CLK_PERIOD_NS;
    // Stabilization wait is 2**(BASE + STEP*select) cycles
    localparam int unsigned STAB_SHIFT_BASE     = 10;
    localparam int unsigned STAB_SHIFT_STEP     = 2;
    localparam int unsigned STAB_SEL_W          = 2;
    localparam int unsigned CNT_W               = 20;

    typedef enum logic [3:0] {
        SWRC_RUN        = 4'h0,
        SWRC_HALT       = 4'h1,
        SWRC_STOP       = 4'h2,
        SWRC_STOP_OSC   = 4'h3,
        SWRC_STOP_STAB  = 4'h4,
        SWRC_STOP_HOLD  = 4'h5,
        SWRC_RST_ACTIVE = 4'h6,
        SWRC_RST_OSC    = 4'h7,
        SWRC_RST_STAB   = 4'h8
    } swrc_state_t;

    typedef struct packed {
        logic halted;
        logic stopped;
        logic waiting;
        logic in_reset;
    } swrc_status_t;

    localparam swrc_status_t STATUS_RESET = 4'h1;
endpackage
`default_nettype wire

//--- rtl/swrc_top.sv
// Standby entry, wake, stabilization and external reset sequencing
`default_nettype none
module swrc_top
    import swrc_pkg::*;
#(
    parameter int unsigned IRQ_N          = 8,
    parameter int unsigned RESTART_CYCLES = RESTART_HOLD_CYCLES
) (
    input  wire logic                  i_sys_clk,
    input  wire logic                  i_reset,
    input  wire logic                  i_ext_reset_n,
    input  wire logic                  i_halt_req,
    input  wire logic                  i_stop_req,
    input  wire logic [IRQ_N-1:0]      i_irq_flag,
    input  wire logic [IRQ_N-1:0]      i_irq_mask,
    input  wire logic                  i_osc_started,
    input  wire logic                  i_lsosc_enable,
    input  wire logic                  i_resonator_used,
    input  wire logic [STAB_SEL_W-1:0] i_stab_time_select,
    input  wire logic [STAB_SEL_W-1:0] i_option_stab_select,
    output logic                       o_cpu_run,
    output logic                       o_sys_osc_en,
    output logic                       o_lsosc_en,
    output logic                       o_int_reset,
    output swrc_status_t               o_status
);

    localparam logic [CNT_W-1:0] EXT_RST_LAST = CNT_W'(EXT_RESET_CYCLES - 1);
    localparam logic [CNT_W-1:0] HOLD_LAST    = CNT_W'(RESTART_CYCLES - 1);

    function automatic logic [CNT_W-1:0] stab_last(input logic [STAB_SEL_W-1:0] sel);
        int unsigned sh;
        sh = STAB_SHIFT_BASE + STAB_SHIFT_STEP * int'(sel);
        return CNT_W'((32'h1 << sh) - 32'h1);
    endfunction

    // States in which the internal reset stays asserted
    function automatic logic is_reset_phase(input swrc_state_t s);
        return (s == SWRC_RST_ACTIVE) || (s == SWRC_RST_OSC) || (s == SWRC_RST_STAB);
    endfunction

    // States in which the core waits for its clock to settle
    function automatic logic is_wait_phase(input swrc_state_t s);
        return (s == SWRC_STOP_OSC) || (s == SWRC_STOP_STAB) || (s == SWRC_STOP_HOLD)
               || (s == SWRC_RST_OSC) || (s == SWRC_RST_STAB);
    endfunction

    // States whose length is measured by the wait counter
    function automatic logic is_timed_wait(input swrc_state_t s);
        return (s == SWRC_STOP_STAB) || (s == SWRC_STOP_HOLD) || (s == SWRC_RST_STAB);
    endfunction

    swrc_state_t      state;
    swrc_state_t      next_state;
    logic [CNT_W-1:0] wait_cnt;
    logic [CNT_W-1:0] rst_lo_cnt;
    logic             ext_rst_seen;
    logic             ls_keep;
    logic             wake;
    logic             wait_done;
    logic             reset_req;

    // A masked request never wakes the core
    assign wake      = |(i_irq_flag & ~i_irq_mask);
    // A recognised pin reset acts exactly like the system reset
    assign reset_req = i_reset | ext_rst_seen;

    // Low level on the reset pin is counted; shorter pulses are ignored
    always_ff @(posedge i_sys_clk) begin
        if (i_reset || i_ext_reset_n) begin
            rst_lo_cnt   <= '0;
            ext_rst_seen <= 1'b0;
        end else if (rst_lo_cnt == EXT_RST_LAST) begin
            ext_rst_seen <= 1'b1;
        end else begin
            rst_lo_cnt <= rst_lo_cnt + CNT_W'(1);
        end
    end

    always_comb begin
        unique case (state)
            SWRC_STOP_STAB: wait_done = (wait_cnt == stab_last(i_stab_time_select));
            SWRC_STOP_HOLD: wait_done = (wait_cnt == HOLD_LAST);
            SWRC_RST_STAB:  wait_done = (wait_cnt == stab_last(i_option_stab_select));
            default:        wait_done = 1'b0;
        endcase
    end

    always_comb begin
        next_state = state;
        if (reset_req) begin
            next_state = SWRC_RST_ACTIVE;
        end else begin
            unique case (state)
                SWRC_RUN: begin
                    // A pending wake cancels entry so the CPU never sleeps
                    if (i_stop_req && !wake) begin
                        next_state = SWRC_STOP;
                    end else if (i_halt_req && !wake) begin
                        next_state = SWRC_HALT;
                    end
                end
                SWRC_HALT: begin
                    if (wake) begin
                        next_state = SWRC_RUN;
                    end
                end
                SWRC_STOP: begin
                    if (wake) begin
                        next_state = SWRC_STOP_OSC;
                    end
                end
                SWRC_STOP_OSC: begin
                    // Start-up time of the oscillator is not part of any timed wait
                    if (i_osc_started) begin
                        next_state = i_resonator_used ? SWRC_STOP_STAB : SWRC_STOP_HOLD;
                    end
                end
                SWRC_STOP_STAB: begin
                    if (wait_done) begin
                        next_state = SWRC_STOP_HOLD;
                    end
                end
                SWRC_STOP_HOLD: begin
                    if (wait_done) begin
                        next_state = SWRC_RUN;
                    end
                end
                // Oscillators restart one cycle after the reset sources clear
                SWRC_RST_ACTIVE: next_state = SWRC_RST_OSC;
                SWRC_RST_OSC: begin
                    if (i_osc_started) begin
                        next_state = SWRC_RST_STAB;
                    end
                end
                SWRC_RST_STAB: begin
                    if (wait_done) begin
                        next_state = SWRC_RUN;
                    end
                end
                default: next_state = SWRC_RST_ACTIVE;
            endcase
        end
    end

    // Reset is folded into next_state too; this branch keeps the register
    // defined from the first reset edge on
    always_ff @(posedge i_sys_clk) begin
        if (i_reset) begin
            state <= SWRC_RST_ACTIVE;
        end else begin
            state <= next_state;
        end
    end

    // Counter restarts on every state change so each wait is measured alone;
    // it rests at zero while the oscillator is still starting up
    always_ff @(posedge i_sys_clk) begin
        if (reset_req || next_state != state) begin
            wait_cnt <= '0;
        end else if (!is_timed_wait(state)) begin
            wait_cnt <= '0;
        end else if (!wait_done) begin
            wait_cnt <= wait_cnt + CNT_W'(1);
        end
    end

    // Remember whether the low-speed oscillator ran when STOP began
    always_ff @(posedge i_sys_clk) begin
        if (reset_req) begin
            ls_keep <= 1'b0;
        end else if (state == SWRC_RUN && next_state == SWRC_STOP) begin
            ls_keep <= o_lsosc_en;
        end
    end

    // System oscillator runs everywhere except in STOP and under reset
    always_ff @(posedge i_sys_clk) begin
        if (reset_req) begin
            o_sys_osc_en <= 1'b0;
        end else begin
            o_sys_osc_en <= (next_state != SWRC_STOP);
        end
    end

    // Slow oscillator follows software except under reset, where it is off, and in STOP, where it keeps its entry value
    always_ff @(posedge i_sys_clk) begin
        if (reset_req) begin
            o_lsosc_en <= 1'b0;
        end else if (next_state == SWRC_STOP) begin
            o_lsosc_en <= (state == SWRC_STOP) ? ls_keep : o_lsosc_en;
        end else begin
            o_lsosc_en <= i_lsosc_enable;
        end
    end

    always_ff @(posedge i_sys_clk) begin
        o_cpu_run <= (next_state == SWRC_RUN);
    end

    // Internal reset covers the oscillator start and the option-byte wait
    always_ff @(posedge i_sys_clk) begin
        o_int_reset <= is_reset_phase(next_state);
    end

    always_ff @(posedge i_sys_clk) begin
        o_status.halted   <= (next_state == SWRC_HALT);
        o_status.stopped  <= (next_state == SWRC_STOP);
        o_status.waiting  <= is_wait_phase(next_state);
        o_status.in_reset <= (next_state == SWRC_RST_ACTIVE);
    end

endmodule
`default_nettype wire

//--- sim/swrc_osc_model.sv
// Oscillator that reports running 21 cycles after its enable rises
`default_nettype none
module swrc_osc_model (
    input  wire logic i_clk,
    input  wire logic i_en,
    output var logic  o_started
);
    timeunit 1ns;
    timeprecision 1ps;
    int cnt = 0;
    always @(posedge i_clk) cnt <= i_en ? cnt + 1 : 0;
    always @(posedge i_clk) o_started <= i_en && cnt >= 20;
endmodule
`default_nettype wire

//--- sim/swrc_top_bench.sv
// Directed bench for the standby and reset control
`default_nettype none
module swrc_top_bench;
    timeunit 1ns / 1ps;
    import swrc_pkg::*;
    logic i_sys_clk = 0, i_reset = 1, i_ext_reset_n = 1, i_halt_req = 0, i_stop_req = 0;
    logic i_lsosc_enable = 1, i_resonator_used = 0, i_osc_started;
    logic [7:0] i_irq_flag = 8'h80, i_irq_mask = 8'hff;
    logic [1:0] i_stab_time_select = 2'h3, i_option_stab_select = 2'h0;
    logic o_cpu_run, o_sys_osc_en, o_lsosc_en, o_int_reset;
    swrc_status_t o_status;
    int error_cnt = 0, check_count = 0, n;
    always #4 i_sys_clk = ~i_sys_clk;
    swrc_top #(.RESTART_CYCLES(8)) dut_u (.i_sys_clk, .i_reset, .i_ext_reset_n, .i_halt_req,
        .i_stop_req, .i_irq_flag, .i_irq_mask, .i_osc_started, .i_lsosc_enable,
        .i_resonator_used, .i_stab_time_select, .i_option_stab_select, .o_cpu_run,
        .o_sys_osc_en, .o_lsosc_en, .o_int_reset, .o_status);
    swrc_osc_model osc_u (.i_clk(i_sys_clk), .i_en(o_sys_osc_en), .o_started(i_osc_started));
    task automatic check(input logic ok, input string msg);
        check_count++;
        if (ok !== 1'b1) begin
            error_cnt++;
            $display("CHECK FAILED at %0t: %s", $time, msg);
        end
    endtask
    task automatic tally_and_finish();
        if (error_cnt == 0 && check_count > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    // Cycles until the CPU runs again must fall in [lo, hi)
    task automatic wait_run(input int lo, input int hi);
        for (n = 0; n < hi && o_cpu_run !== 1'b1; n++) @(negedge i_sys_clk);
        check(n >= lo && n < hi, "restart time out of range");
        if (n >= hi) tally_and_finish();
    endtask
    task automatic pulse(input logic [1:0] req);
        {i_stop_req, i_halt_req} = req;
        @(negedge i_sys_clk);
        {i_stop_req, i_halt_req} = 2'h0;
        repeat (3) @(negedge i_sys_clk);
    endtask
    initial begin
        repeat (12) @(negedge i_sys_clk);
        check(o_status === STATUS_RESET && o_int_reset === 1'b1, "reset status wrong");
        check(o_sys_osc_en === 1'b0 && o_lsosc_en === 1'b0, "osc on in reset");
        i_reset = 0;
        wait_run(1024, 1200);
        i_ext_reset_n = 0;
        repeat (249) @(negedge i_sys_clk);
        i_ext_reset_n = 1;
        repeat (3) @(negedge i_sys_clk);
        check(o_cpu_run === 1'b1 && o_int_reset === 1'b0, "short reset pulse taken");
        pulse(2'h1);
        check(o_cpu_run === 1'b0 && o_status.halted === 1'b1, "halt not entered");
        i_irq_mask = 8'h7f;
        repeat (2) @(negedge i_sys_clk);
        check(o_cpu_run === 1'b1 && o_status === 4'h0, "halt wake late");
        i_irq_mask = 8'hff;
        pulse(2'h2);
        i_lsosc_enable = 0;
        repeat (3) @(negedge i_sys_clk);
        check(o_status.stopped === 1'b1 && o_lsosc_en === 1'b1, "slow osc lost in stop");
        i_irq_mask = 8'h7f;
        wait_run(28, 60);
        pulse(2'h1);
        check(o_cpu_run === 1'b1 && o_status === 4'h0, "halt taken with wake pending");
        pulse(2'h2);
        check(o_cpu_run === 1'b1 && o_sys_osc_en === 1'b1, "stop taken with wake pending");
        {i_irq_mask, i_resonator_used, i_stab_time_select} = {8'hff, 1'b1, 2'h1};
        pulse(2'h2);
        i_irq_mask = 8'h7f;
        wait_run(4116, 4200);
        {i_ext_reset_n, i_option_stab_select, i_stab_time_select} = {1'b0, 2'h1, 2'h0};
        repeat (260) @(negedge i_sys_clk);
        check(o_int_reset === 1'b1 && o_status === STATUS_RESET, "pin reset not taken");
        check(o_lsosc_en === 1'b0 && o_sys_osc_en === 1'b0, "osc on in pin reset");
        i_ext_reset_n = 1;
        wait_run(4096, 4300);
        tally_and_finish();
    end
endmodule
`default_nettype wire

//--- sim/swrc_top_props.sv
// Port assertions for the standby and reset control
`default_nettype none
module swrc_top_props
    import swrc_pkg::*;
#(parameter int unsigned IRQ_N = 8) (
    input wire logic             i_sys_clk,
    input wire logic             i_reset,
    input wire logic [IRQ_N-1:0] i_irq_flag,
    input wire logic [IRQ_N-1:0] i_irq_mask,
    input wire logic             o_cpu_run,
    input wire logic             o_sys_osc_en,
    input wire logic             o_lsosc_en,
    input wire logic             o_int_reset,
    input wire swrc_status_t     o_status
);
    timeunit 1ns;
    timeprecision 1ps;
    wire logic pend = |(i_irq_flag & ~i_irq_mask);
    default clocking @(posedge i_sys_clk); endclocking
    default disable iff (i_reset);
    // A reset from the pin may still stop a running core
    a_wake_cancel: assert property (o_cpu_run && pend |=> (o_cpu_run || o_int_reset))
        else $error("entry with wake pending");
    a_halt_wake: assert property (o_status.halted && pend
        |=> o_cpu_run && !o_status.halted)
        else $error("halt wake late");
    a_stop_wake: assert property (o_status.stopped && pend
        |=> o_status.waiting && o_sys_osc_en)
        else $error("stop wake late");
    a_lsosc_hold: assert property (o_status.stopped |-> $stable(o_lsosc_en))
        else $error("slow osc changed in stop");
    a_stop_hold: assert property ($fell(o_status.stopped) |-> !o_cpu_run [*8])
        else $error("stop hold too short");
    a_reset_osc: assert property (o_status.in_reset |-> !o_sys_osc_en && !o_lsosc_en)
        else $error("osc on in reset");
endmodule
bind swrc_top swrc_top_props #(.IRQ_N(IRQ_N)) u_props (.i_sys_clk, .i_reset, .i_irq_flag,
    .i_irq_mask, .o_cpu_run, .o_sys_osc_en, .o_lsosc_en, .o_int_reset, .o_status);
`default_nettype wire
